// file: inc/lcr_pkg.sv
package lcr_pkg;
   // Register map.
   localparam logic [11:0] LINK_CAP_ADDR  = 12'h04C;
   localparam logic [11:0] LINK_CTL_ADDR  = 12'h050;
   localparam logic [11:0] SWITCH_CTL_ADDR = 12'h060;
   // Field positions.
   localparam int SPEED_LSB     = 0;
   localparam int WIDTH_LSB     = 4;
   localparam int LPS_LSB       = 10;
   localparam int STANDBY_LSB   = 12;
   localparam int DEEP_LSB      = 15;
   localparam int REFCLK_BIT    = 18;
   localparam int LOSS_BIT      = 19;
   localparam int ACTIVE_BIT    = 20;
   localparam int BWN_BIT       = 21;
   localparam int PORT_LSB      = 24;
   localparam int SHARED_CLK_BIT = 6;
   localparam int UNLOCK_BIT    = 0;
   // Reset and fixed values.
   localparam logic [3:0] SPEED_RST        = 4'h1;
   localparam logic [1:0] LPS_VAL          = 2'h3;
   localparam logic [2:0] STANDBY_SEP      = 3'h5;
   localparam logic [2:0] STANDBY_COMMON   = 3'h3;
   localparam logic [2:0] DEEP_RST         = 3'h2;
   localparam logic [5:0] WIDTH_X1         = 6'h01;
   localparam logic [7:0] PORT_MAX         = 8'h06;
   // Fixed L1 exit time, in nanoseconds, and its length in 50 ns cycles.
   localparam int DEEP_EXIT_NS   = 2300;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int DEEP_EXIT_CYC  = (DEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: design/lcr_width_decode.sv
`timescale 1ns/100ps
module lcr_width_decode (
   // Field in.
   input  wire logic [5:0] widthCode,
   // Effective lane count.
   output logic      [5:0] trainWidth,
   output logic            widthValid
);
   function automatic logic lcr_valid(input logic [5:0] c);
      case (c)
         6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20: lcr_valid = 1'b1;
         default: lcr_valid = 1'b0;
      endcase
   endfunction

   always_comb begin
      widthValid = lcr_valid(widthCode);
      trainWidth = widthValid ? widthCode : lcr_pkg::WIDTH_X1;
   end
endmodule

// file: design/lcr_reg_write.sv
`timescale 1ns/100ps
module lcr_reg_write (
   // Merge of a write into a lockable field.
   input  wire logic        unlock,
   input  wire logic        wrHit,
   input  wire logic [31:0] wrData,
   input  wire logic [31:0] curVal,
   input  wire logic [31:0] lockMask,
   output logic      [31:0] nextVal
);
   always_comb begin
      if (wrHit && unlock) begin
         nextVal = (curVal & ~lockMask) | (wrData & lockMask);
      end else begin
         nextVal = curVal;
      end
   end
endmodule

// file: design/lcr_link_cap.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
// Contract
// - Speed field 3:0 read-only, resets 1
// - Lane width 9:4, physical width, rewritable
// - Invalid lane width trains as x1
// - Valid widths 1,2,4,8,12,16,32 only
// - Low-power support 11:10 fixed 3
// - Standby latency 5 separate, 3 shared
// - Deep idle latency 17:15 resets 2
// - Refclk removal bit 18 resets 0
// - Link-loss bit 19: up 0, down 1
// - Link-active bit 20: down 1, up 0
// - Bandwidth notify bit 21: down 1, up 0
// - Old revision mode clears bandwidth notify
// - Bits 31:24 return port index, capped at 6
// - Shared refclk bit selects standby latency
module lcr_link_cap (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Port identity and straps, from same-clock logic.
   input  wire logic [7:0]  portIndex,
   input  wire logic [5:0]  physLaneWidth,
   input  wire logic        legacyRevMode,
   // Register port.
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdData,
   // Link trainer.
   output logic      [5:0]  trainWidth,
   output logic      [2:0]  standbyExitLatency,
   output logic             sharedRefclkConfig,
   output logic             registerWriteUnlock
);
   typedef struct packed {
      logic [31:0] cap;
      logic        loaded;
      logic        sharedClk;
      logic        unlock;
      logic [31:0] rdData;
   } lcr_state_s;

   lcr_state_s st_r;
   lcr_state_s st_nxt;
   logic [31:0] capView;
   logic [31:0] capMerged;
   logic [31:0] lockMask;
   logic        isUp;
   logic        widthValid;

   assign isUp = (portIndex == 8'h00);
   assign lockMask = 32'h003F_F3F0;

   always_comb begin
      capView = st_r.cap;
      capView[3:0]   = lcr_pkg::SPEED_RST;
      capView[11:10] = lcr_pkg::LPS_VAL;
      capView[14:12] = st_r.sharedClk ? lcr_pkg::STANDBY_COMMON
                                      : lcr_pkg::STANDBY_SEP;
      capView[23:22] = 2'h0;
      capView[31:24] = (portIndex > lcr_pkg::PORT_MAX) ? lcr_pkg::PORT_MAX
                                                      : portIndex;
      if (isUp) begin
         capView[lcr_pkg::ACTIVE_BIT] = 1'b0;
         capView[lcr_pkg::BWN_BIT]    = 1'b0;
      end
   end

   lcr_reg_write u_wr (
      .unlock   (st_r.unlock),
      .wrHit    (regWrite && regAddr == lcr_pkg::LINK_CAP_ADDR),
      .wrData   (regWrData),
      .curVal   (st_r.cap),
      .lockMask (lockMask),
      .nextVal  (capMerged)
   );

   lcr_width_decode u_dec (
      .widthCode  (st_r.cap[9:4]),
      .trainWidth (trainWidth),
      .widthValid (widthValid)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.cap = capMerged;
      // Capture strap-derived defaults on the first cycle after reset.
      if (!st_r.loaded) begin
         st_nxt.loaded = 1'b1;
         st_nxt.cap = 32'h0000_0000;
         st_nxt.cap[9:4]   = physLaneWidth;
         st_nxt.cap[17:15] = lcr_pkg::DEEP_RST;
         st_nxt.cap[lcr_pkg::REFCLK_BIT] = 1'b0;
         st_nxt.cap[lcr_pkg::LOSS_BIT]   = !isUp;
         st_nxt.cap[lcr_pkg::ACTIVE_BIT] = !isUp;
         st_nxt.cap[lcr_pkg::BWN_BIT]    = !isUp && !legacyRevMode;
      end
      if (regWrite && regAddr == lcr_pkg::LINK_CTL_ADDR) begin
         st_nxt.sharedClk = regWrData[lcr_pkg::SHARED_CLK_BIT];
      end
      if (regWrite && regAddr == lcr_pkg::SWITCH_CTL_ADDR) begin
         st_nxt.unlock = regWrData[lcr_pkg::UNLOCK_BIT];
      end
      st_nxt.rdData = 32'h0000_0000;
      if (regRead) begin
         case (regAddr)
            lcr_pkg::LINK_CAP_ADDR: st_nxt.rdData = capView;
            lcr_pkg::LINK_CTL_ADDR: begin
               st_nxt.rdData[lcr_pkg::SHARED_CLK_BIT] = st_r.sharedClk;
            end
            lcr_pkg::SWITCH_CTL_ADDR: begin
               st_nxt.rdData[lcr_pkg::UNLOCK_BIT] = st_r.unlock;
            end
            default: st_nxt.rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdData           = st_r.rdData;
   assign standbyExitLatency  = capView[14:12];
   assign sharedRefclkConfig  = st_r.sharedClk;
   assign registerWriteUnlock = st_r.unlock;
endmodule

// file: sim/lcr_link_cap_chk.sv
`timescale 1ns/100ps
module lcr_link_cap_chk (
   // Clock and reset.
   input wire logic        ref_clk,
   input wire logic        rst,
   // Register port.
   input wire logic [7:0]  portIndex,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdData,
   // Link trainer.
   input wire logic [5:0]  trainWidth,
   input wire logic [2:0]  standbyExitLatency,
   input wire logic        sharedRefclkConfig,
   input wire logic        registerWriteUnlock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire capRd = regRead && regAddr == lcr_pkg::LINK_CAP_ADDR;
   wire capWr = regWrite && regAddr == lcr_pkg::LINK_CAP_ADDR && registerWriteUnlock;
   a_speed_fixed: assert property (capRd |=> regRdData[3:0] == 4'h1)
      else $error("speed field wrong");
   a_power_fixed: assert property (capRd |=> regRdData[11:10] == 2'h3)
      else $error("power support field wrong");
   a_port_index: assert property (capRd |=> regRdData[31:24] ==
      (portIndex > 8'h06 ? 8'h06 : portIndex)) else $error("port field wrong");
   a_standby_sel: assert property (standbyExitLatency ==
      (sharedRefclkConfig ? 3'h3 : 3'h5)) else $error("standby latency wrong");
   a_standby_read: assert property (capRd |=>
      regRdData[14:12] == $past(standbyExitLatency)) else $error("standby read wrong");
   a_width_legal: assert property (trainWidth inside {1, 2, 4, 8, 12, 16, 32})
      else $error("illegal train width");
   a_upstream_zero: assert property (capRd && portIndex == 8'h00 |=>
      regRdData[21:20] == 2'b00) else $error("upstream bits set");
   a_width_locked: assert property (!$past(rst, 2) && !$past(capWr) |->
      $stable(trainWidth)) else $error("width changed while locked");
   a_unlock_write: assert property (regWrite &&
      regAddr == lcr_pkg::SWITCH_CTL_ADDR |=> registerWriteUnlock == $past(regWrData[0]))
      else $error("unlock bit not written");
   cover property (capRd);
   cover property (capWr);
   cover property (sharedRefclkConfig && capRd);
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
   logic        ref_clk = 0, rst = 1, legacyRevMode = 0, regWrite = 0, regRead = 0;
   logic [7:0]  portIndex = 0;
   logic [5:0]  physLaneWidth = 0, trainWidth;
   logic [11:0] regAddr = 0;
   logic [31:0] regWrData = 0, regRdData;
   logic [2:0]  standbyExitLatency;
   logic        sharedRefclkConfig, registerWriteUnlock;
   int          errors = 0, checks_done = 0, cycles = 0;
   localparam logic [11:0] CAP = lcr_pkg::LINK_CAP_ADDR;
   lcr_link_cap dut (.ref_clk(ref_clk), .rst(rst), .portIndex(portIndex),
      .physLaneWidth(physLaneWidth), .legacyRevMode(legacyRevMode), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .trainWidth(trainWidth), .standbyExitLatency(standbyExitLatency),
      .sharedRefclkConfig(sharedRefclkConfig), .registerWriteUnlock(registerWriteUnlock));
   initial forever #25 ref_clk = ~ref_clk;
   function automatic logic [31:0] cv(logic [7:0] p, logic [5:0] w, logic [2:0] d,
      logic [3:0] hi, logic [2:0] s);
      return {p, 2'b00, hi, d, s, 2'h3, w, 4'h1};
   endfunction
   task automatic cfg(logic [7:0] p, logic [5:0] w, logic leg);
      rst <= 1'b1;
      portIndex <= p;
      physLaneWidth <= w;
      legacyRevMode <= leg;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e, string n);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 `CHK(n, e, regRdData)
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         stop_test;
      end
   end
   initial begin
      cfg(8'h00, 6'h10, 1'b0);
      rd(CAP, cv(8'h00, 6'h10, 3'h2, 4'h0, 3'h5), "up");
      `CHK("width", 6'h10, trainWidth)
      cfg(8'h03, 6'h08, 1'b0);
      rd(CAP, cv(8'h03, 6'h08, 3'h2, 4'he, 3'h5), "down");
      wr(CAP, 32'hFFFF_FFFF);
      rd(CAP, cv(8'h03, 6'h08, 3'h2, 4'he, 3'h5), "locked");
      wr(lcr_pkg::SWITCH_CTL_ADDR, 32'h0000_0001);
      wr(CAP, 32'hFFFF_FFFF);
      rd(CAP, cv(8'h03, 6'h3f, 3'h7, 4'hf, 3'h5), "open");
      `CHK("bad width", 6'h01, trainWidth)
      wr(CAP, 32'h0000_00C0);
      `CHK("x12", 6'h0c, trainWidth)
      wr(lcr_pkg::LINK_CTL_ADDR, 32'h0000_0040);
      rd(lcr_pkg::LINK_CTL_ADDR, 32'h0000_0040, "ctl");
      rd(CAP, cv(8'h03, 6'h0c, 3'h0, 4'h0, 3'h3), "shared");
      rd(12'h100, 32'h0000_0000, "unmapped");
      cfg(8'h09, 6'h05, 1'b1);
      rd(CAP, cv(8'h06, 6'h05, 3'h2, 4'h6, 3'h5), "legacy");
      `CHK("x1", 6'h01, trainWidth)
      stop_test;
   end
endmodule
bind lcr_link_cap lcr_link_cap_chk chk (.ref_clk(ref_clk), .rst(rst), .portIndex(portIndex),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .trainWidth(trainWidth), .standbyExitLatency(standbyExitLatency),
   .sharedRefclkConfig(sharedRefclkConfig), .registerWriteUnlock(registerWriteUnlock));
